// >>> logic/dcc_channel.sv
// One comparator channel: input selection, compare, sync, change flag
`timescale 1ns/1ps
`default_nettype none
module dcc_channel (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire dcc_pkg::dcc_cfg_t cfg_i, // Channel configuration
  input wire dcc_pkg::dcc_ain_t ain_i, // Analog-side levels (digital model)
  input wire logic flag_clr_i, // Software clear of the change flag
  output logic raw_o, // Unsynchronised compare result
  output logic result_o, // Synchronised result
  output logic change_o, // Change flag
  output logic settled_o // Settling time elapsed
);
  import dcc_pkg::*;
  logic pos_lvl;
  logic neg_lvl;
  logic cmp_s;
  logic [DCC_SETTLE_W-1:0] settle_cnt_r;
  // ==========================================================
  // Input selection and compare, modelled on digital levels
  assign pos_lvl = cfg_i.pos_sel ? ain_i.pin_b : ain_i.pin_a;
  assign neg_lvl = cfg_i.neg_sel ? ain_i.int_ref : ain_i.ext_ref;
  assign raw_o = cfg_i.on & pos_lvl & ~neg_lvl;
  // Result crosses into the CPU clock through two flops
  dcc_sync2 u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i(raw_o),
    .q_o(cmp_s)
  );
  // ==========================================================
  // Result bit, forced low while off
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !cfg_i.on) begin
      result_o <= 1'b0;
    end else begin
      result_o <= cmp_s;
    end
  end
  // Change flag: set wins over software clear, disable clears outright
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !cfg_i.on) begin
      change_o <= 1'b0;
    end else if (cmp_s != result_o) begin
      change_o <= 1'b1;
    end else if (flag_clr_i) begin
      change_o <= 1'b0;
    end
  end
  // Settling counter; informs software only, does not gate the result
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !cfg_i.on) begin
      settle_cnt_r <= '0;
    end else if (settle_cnt_r != DCC_SETTLE_W'(DCC_SETTLE_CYC)) begin
      settle_cnt_r <= settle_cnt_r + 1'b1;
    end
  end
  assign settled_o = (settle_cnt_r == DCC_SETTLE_W'(DCC_SETTLE_CYC));
endmodule
`default_nettype wire

// >>> logic/dcc_pkg.sv
// Package: register map, field layout and timing constants of the comparator control block
package dcc_pkg;
  // ==========================================================
  // Register indices (byte-wide special function registers)
  localparam logic [7:0] DCC_OFF_COMPARATOR_ONE_CONTROL = 8'h00_AC;
  localparam logic [7:0] DCC_OFF_COMPARATOR_TWO_CONTROL = 8'h00_AD;
  localparam logic [7:0] DCC_OFF_P0AD = 8'h00_F6;
  localparam logic [7:0] DCC_OFF_IRQ_STAT = 8'h00_B0;
  localparam logic [7:0] DCC_OFF_IRQ_MASK = 8'h00_B1;
  localparam logic [7:0] DCC_OFF_P0_READ = 8'h00_80;
  // ==========================================================
  // Control register field positions
  localparam int DCC_BIT_ON = 5;
  localparam int DCC_BIT_POS = 4;
  localparam int DCC_BIT_NEG = 3;
  localparam int DCC_BIT_OE = 2;
  localparam int DCC_BIT_RES = 1;
  localparam int DCC_BIT_FLAG = 0;
  localparam logic [7:0] DCC_CTRL_WMASK = 8'h00_3C;
  // ==========================================================
  // Reset values
  localparam logic [7:0] DCC_CTRL_RST = 8'h00_00;
  localparam logic [7:0] DCC_P0AD_RST = 8'h00_00;
  localparam logic [1:0] DCC_MASK_RST = 2'h0;
  // ==========================================================
  // Settling time after enable
  localparam int DCC_CLK_HZ = 20_000_000;
  localparam int DCC_SETTLE_US = 10;
  localparam int DCC_SETTLE_CYC = (DCC_SETTLE_US * (DCC_CLK_HZ / 1_000_000));
  localparam int DCC_SETTLE_W = 8;
  // ==========================================================
  // Per-comparator configuration carried to the channel
  typedef struct packed {
    logic on;
    logic pos_sel;
    logic neg_sel;
    logic oe;
  } dcc_cfg_t;
  // Analog-side inputs of one comparator
  typedef struct packed {
    logic pin_a;
    logic pin_b;
    logic ext_ref;
    logic int_ref;
  } dcc_ain_t;
endpackage

// >>> logic/dcc_sync2.sv
// Two-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module dcc_sync2 (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic d_i, // Asynchronous level
  output logic q_o // Synchronised level
);
  logic meta_r;
  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> logic/dcc_top.sv
// Top level: dual comparator control registers, port 0 input disable, interrupt
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
module dcc_top (
  input wire logic clk_sys_i, // CPU clock, 20 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [7:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  input wire logic [1:0] comparator_irq_enable_i, // Per-comparator enable bits
  input wire logic global_irq_enable_i, // Global interrupt enable
  input wire dcc_pkg::dcc_ain_t ain1_i, // Comparator one analog levels
  input wire dcc_pkg::dcc_ain_t ain2_i, // Comparator two analog levels
  input wire logic [7:0] port0_pin_i, // Port 0 pin levels (asynchronous)
  output logic [7:0] port0_in_en_o, // Digital input buffer enables
  output logic [1:0] cmp_pin_o, // Comparator output pin levels
  output logic [1:0] cmp_pin_oe_o, // Comparator output pin enables
  output logic [1:0] settled_o, // Settling time elapsed per channel
  output logic irq_o // Level interrupt request
);
  import dcc_pkg::*;
  dcc_cfg_t cfg_r [2];
  dcc_ain_t ain [2];
  logic [7:0] port0_input_disable_r;
  logic [1:0] irq_mask_r;
  logic [1:0] raw;
  logic [1:0] result;
  logic [1:0] change;
  logic [1:0] settled;
  logic [1:0] flag_clr;
  logic [7:0] p0_sync;
  logic [7:0] rdata_nxt;
  logic [1:0] irq_en_s;
  logic gie_s;
  assign ain[0] = ain1_i;
  assign ain[1] = ain2_i;
  // ==========================================================
  // Per-channel control, compare and routing
  for (genvar g = 0; g < 2; g++) begin : g_ch
    localparam logic [7:0] OFF = (g == 0) ? DCC_OFF_COMPARATOR_ONE_CONTROL : DCC_OFF_COMPARATOR_TWO_CONTROL;
    // Software write of the control byte; the result bit is read-only, the flag bit is never set by a write and clears on a zero write
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        cfg_r[g] <= dcc_cfg_t'(4'h0);
      end else if (wr_i && addr_i == OFF) begin
        cfg_r[g].on <= wdata_i[DCC_BIT_ON];
        cfg_r[g].pos_sel <= wdata_i[DCC_BIT_POS];
        cfg_r[g].neg_sel <= wdata_i[DCC_BIT_NEG];
        cfg_r[g].oe <= wdata_i[DCC_BIT_OE];
      end
    end
    // Writing zero to the flag bit, or one to its bit in the status register, clears it
    assign flag_clr[g] = wr_i && ((addr_i == OFF && !wdata_i[DCC_BIT_FLAG]) ||
                                  (addr_i == DCC_OFF_IRQ_STAT && wdata_i[g]));
    dcc_channel u_ch (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .cfg_i(cfg_r[g]),
      .ain_i(ain[g]),
      .flag_clr_i(flag_clr[g]),
      .raw_o(raw[g]),
      .result_o(result[g]),
      .change_o(change[g]),
      .settled_o(settled[g])
    );
    // Raw result to pin; one flop keeps the output registered
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        cmp_pin_o[g] <= 1'b0;
        cmp_pin_oe_o[g] <= 1'b0;
      end else begin
        cmp_pin_o[g] <= raw[g] & cfg_r[g].oe;
        cmp_pin_oe_o[g] <= cfg_r[g].on & cfg_r[g].oe;
      end
    end
  end
  // ==========================================================
  // Port 0 input disable register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      port0_input_disable_r <= DCC_P0AD_RST;
    end else if (wr_i && addr_i == DCC_OFF_P0AD) begin
      port0_input_disable_r <= wdata_i;
    end
  end
  // Buffer enables leave as flops
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      port0_in_en_o <= ~DCC_P0AD_RST;
    end else begin
      port0_in_en_o <= ~port0_input_disable_r;
    end
  end
  // Pins cross in through two flops each
  for (genvar b = 0; b < 8; b++) begin : g_p0
    dcc_sync2 u_ps (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .d_i(port0_pin_i[b]),
      .q_o(p0_sync[b])
    );
  end
  // ==========================================================
  // Interrupt mask register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_mask_r <= DCC_MASK_RST;
    end else if (wr_i && addr_i == DCC_OFF_IRQ_MASK) begin
      irq_mask_r <= wdata_i[1:0];
    end
  end
  // Enable levels come from the CPU side but may be async in practice
  for (genvar e = 0; e < 2; e++) begin : g_ie
    dcc_sync2 u_es (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .d_i(comparator_irq_enable_i[e]),
      .q_o(irq_en_s[e])
    );
  end
  dcc_sync2 u_gs (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i(global_irq_enable_i),
    .q_o(gie_s)
  );
  // Level request; no clock gating so it still wakes from low power
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= gie_s && |(change & irq_mask_r & irq_en_s);
    end
  end
  // ==========================================================
  // Read mux
  always_comb begin
    rdata_nxt = 8'h00_00;
    unique case (addr_i)
      DCC_OFF_COMPARATOR_ONE_CONTROL, DCC_OFF_COMPARATOR_TWO_CONTROL: begin
        for (int i = 0; i < 2; i++) begin
          if (addr_i == ((i == 0) ? DCC_OFF_COMPARATOR_ONE_CONTROL : DCC_OFF_COMPARATOR_TWO_CONTROL)) begin
            rdata_nxt[DCC_BIT_ON] = cfg_r[i].on;
            rdata_nxt[DCC_BIT_POS] = cfg_r[i].pos_sel;
            rdata_nxt[DCC_BIT_NEG] = cfg_r[i].neg_sel;
            rdata_nxt[DCC_BIT_OE] = cfg_r[i].oe;
            rdata_nxt[DCC_BIT_RES] = result[i];
            rdata_nxt[DCC_BIT_FLAG] = change[i];
          end
        end
      end
      DCC_OFF_P0AD: rdata_nxt = port0_input_disable_r;
      DCC_OFF_IRQ_STAT: rdata_nxt = {6'h00, change};
      DCC_OFF_IRQ_MASK: rdata_nxt = {6'h00, irq_mask_r};
      DCC_OFF_P0_READ: rdata_nxt = p0_sync & ~port0_input_disable_r;
      default: rdata_nxt = 8'h00_00;
    endcase
  end
  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00_00;
    end else begin
      rdata_o <= rd_i ? rdata_nxt : 8'h00_00;
    end
  end
  // Settling indication for software polling
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      settled_o <= 2'h0;
    end else begin
      settled_o <= settled;
    end
  end
endmodule
`default_nettype wire

// >>> test/dcc_analog.sv
// Partner model: analog levels and port 0 pin levels at the block's far side
`timescale 1ns/1ps
`default_nettype none
module dcc_analog (
  input wire logic clk_sys_i, // Clock
  input wire logic [3:0] lvl1_i, // Comparator one levels, a b ext int
  input wire logic [3:0] lvl2_i, // Comparator two levels
  input wire logic [7:0] pins_i, // Port 0 pin levels
  output var dcc_pkg::dcc_ain_t ain1_o, // Comparator one inputs
  output var dcc_pkg::dcc_ain_t ain2_o, // Comparator two inputs
  output logic [7:0] port0_o // Port 0 pins
);
  import dcc_pkg::*;
  // One cycle of lag, so the block never sees a level change at the bus edge
  always_ff @(posedge clk_sys_i) begin
    ain1_o <= dcc_ain_t'(lvl1_i);
    ain2_o <= dcc_ain_t'(lvl2_i);
    port0_o <= pins_i;
  end
endmodule
`default_nettype wire

// >>> test/dcc_top_asserts.sv
// Checker: port-level properties of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module dcc_top_asserts (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [7:0] addr_i, // Address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [7:0] rdata_o, // Read data
  input wire logic [1:0] comparator_irq_enable_i, // Irq enables
  input wire logic global_irq_enable_i, // Global enable
  input wire logic [7:0] port0_in_en_o, // Input buffer enables
  input wire logic [1:0] cmp_pin_oe_o, // Pin enables
  input wire logic [1:0] settled_o, // Settled flags
  input wire logic irq_o // Interrupt
);
  import dcc_pkg::*;
  logic on1_r;
  logic [1:0] mask_r;
  logic [7:0] cnt1_r;
  logic c1_wr;
  logic c1_rd;
  logic p0_wr;
  logic c1_oe;
  logic mapped;
  // Bus decodes
  assign c1_wr = wr_i && addr_i == DCC_OFF_COMPARATOR_ONE_CONTROL;
  assign c1_rd = rd_i && addr_i == DCC_OFF_COMPARATOR_ONE_CONTROL;
  assign p0_wr = wr_i && addr_i == DCC_OFF_P0AD;
  assign c1_oe = wdata_i[DCC_BIT_ON] & wdata_i[DCC_BIT_OE];
  assign mapped = addr_i inside {DCC_OFF_COMPARATOR_ONE_CONTROL, DCC_OFF_COMPARATOR_TWO_CONTROL, DCC_OFF_P0AD, DCC_OFF_IRQ_STAT,
    DCC_OFF_IRQ_MASK, DCC_OFF_P0_READ};
  // Shadow of enable and mask, updated at the same edge as the design
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      on1_r <= 1'b0;
      mask_r <= 2'h0;
    end else if (c1_wr) begin
      on1_r <= wdata_i[DCC_BIT_ON];
    end else if (wr_i && addr_i == DCC_OFF_IRQ_MASK) begin
      mask_r <= wdata_i[1:0];
    end
  end
  // Run length of the enable, saturating so it never wraps into a false low count
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !on1_r) begin
      cnt1_r <= 8'h00;
    end else if (cnt1_r != 8'hFF) begin
      cnt1_r <= cnt1_r + 8'h01;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  idle_rdata_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata not idle");
  unmapped_read_a: assert property ($past(rd_i) && !$past(mapped) |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  off_result_a: assert property ($past(c1_rd) && !$past(on1_r) && !$past(on1_r, 2) |->
    rdata_o[1:0] == 2'h0) else $error("result or flag set while off");
  in_en_a: assert property ($past(p0_wr, 2) && !$past(p0_wr) |->
    port0_in_en_o == ~$past(wdata_i, 2)) else $error("input enable wrong");
  pin_oe_a: assert property ($past(c1_wr, 2) && !$past(c1_wr) |->
    cmp_pin_oe_o[0] == $past(c1_oe, 2)) else $error("pin enable wrong");
  settle_rise_a: assert property ($rose(settled_o[0]) |->
    cnt1_r >= 8'hC5 && cnt1_r <= 8'hCB) else $error("settled early or late");
  settle_hold_a: assert property (cnt1_r == 8'hCD |-> settled_o[0])
    else $error("settled missing");
  irq_cause_a: assert property (irq_o |-> $past(global_irq_enable_i, 3) &&
    ($past(mask_r) & $past(comparator_irq_enable_i, 3)) != 2'h0)
    else $error("irq without enables");
  irq_off_a: assert property (irq_o && $past(mask_r) == 2'h1 |-> $past(on1_r, 2))
    else $error("irq while disabled");
endmodule
bind dcc_top dcc_top_asserts dcc_top_asserts_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .comparator_irq_enable_i(comparator_irq_enable_i), .global_irq_enable_i(global_irq_enable_i),
  .port0_in_en_o(port0_in_en_o), .cmp_pin_oe_o(cmp_pin_oe_o), .settled_o(settled_o),
  .irq_o(irq_o));
`default_nettype wire

// >>> test/tb.sv
// Testbench: registers, comparator configurations, port 0 and interrupt path
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dcc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [1:0] ien = 2'h0;
  logic gie = 1'b0;
  logic [3:0] lvl1 = 4'h0;
  logic [3:0] lvl2 = 4'h0;
  logic [7:0] pins = 8'h00;
  logic [7:0] rdata_o, port0_in_en_o, pin0;
  logic [1:0] cmp_pin_o, cmp_pin_oe_o, settled_o;
  logic irq_o;
  dcc_ain_t ain1, ain2;
  int mismatches = 0;
  int compares = 0;
  dcc_analog dcc_analog_inst (.clk_sys_i(clk_sys_i), .lvl1_i(lvl1), .lvl2_i(lvl2),
    .pins_i(pins), .ain1_o(ain1), .ain2_o(ain2), .port0_o(pin0));
  dcc_top dcc_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .comparator_irq_enable_i(ien), .global_irq_enable_i(gie), .ain1_i(ain1), .ain2_i(ain2),
    .port0_pin_i(pin0), .port0_in_en_o(port0_in_en_o), .cmp_pin_o(cmp_pin_o),
    .cmp_pin_oe_o(cmp_pin_oe_o), .settled_o(settled_o), .irq_o(irq_o));
  // 20 MHz clock
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Expected compare from levels {a, b, ext, int} and select bits {pos, neg, oe}
  function automatic logic exp_res(input logic [2:0] c, input logic [3:0] l);
    return (c[2] ? l[2] : l[3]) & ~(c[1] ? l[0] : l[1]);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus cycles leave a gap cycle so a strobe is never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
    @(posedge clk_sys_i);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic end_of_test;
    $display("Counts: mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the roughly five hundred cycles of the tests
  initial begin
    #500_000;
    mismatches++;
    end_of_test;
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] p;
    logic [7:0] d;
    logic [7:0] ctl;
    logic r;
    void'($urandom(32'hdca15a54));
    tick(12);
    rst_i <= 1'b0;
    tick(1);
    chk(port0_in_en_o, 8'hFF);
    rd(DCC_OFF_COMPARATOR_TWO_CONTROL, d);
    chk(d, DCC_CTRL_RST);
    rd(8'h55, d);
    chk(d, 8'h00);
    // Input disable against random pin levels
    repeat (4) begin
      v = 8'($urandom);
      p = 8'($urandom);
      pins <= p;
      wr(DCC_OFF_P0AD, v);
      tick(2);
      chk(port0_in_en_o, ~v);
      rd(DCC_OFF_P0_READ, d);
      chk(d, p & ~v);
      rd(DCC_OFF_P0AD, d);
      chk(d, v);
    end
    // Every select and output configuration, with the comparator on, on both channels, random levels
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 8; c++) begin
        v = 8'($urandom);
        lvl1 <= v[3:0];
        lvl2 <= v[7:4];
        ctl = 8'h20 | 8'(c << 2);
        wr(ch ? DCC_OFF_COMPARATOR_TWO_CONTROL : DCC_OFF_COMPARATOR_ONE_CONTROL, ctl);
        tick(6);
        r = exp_res(3'(c), ch ? v[7:4] : v[3:0]);
        rd(ch ? DCC_OFF_COMPARATOR_TWO_CONTROL : DCC_OFF_COMPARATOR_ONE_CONTROL, d);
        chk(d & 8'hFE, ctl | {6'h00, r, 1'b0});
        chk({7'h00, cmp_pin_oe_o[ch]}, {7'h00, ctl[2]});
        chk({7'h00, cmp_pin_o[ch]}, {7'h00, r & ctl[2]});
      end
    end
    // Interrupt path on comparator one
    wr(DCC_OFF_COMPARATOR_ONE_CONTROL, 8'h00);
    wr(DCC_OFF_COMPARATOR_TWO_CONTROL, 8'h00);
    lvl1 <= 4'h0;
    wr(DCC_OFF_COMPARATOR_ONE_CONTROL, 8'h20);
    tick(10);
    chk({7'h00, settled_o[0]}, 8'h00);
    tick(200);
    chk({7'h00, settled_o[0]}, 8'h01);
    wr(DCC_OFF_COMPARATOR_ONE_CONTROL, 8'h20);
    wr(DCC_OFF_IRQ_MASK, 8'h01);
    rd(DCC_OFF_IRQ_MASK, d);
    chk(d, 8'h01);
    ien <= 2'b11;
    gie <= 1'b1;
    tick(5);
    chk({7'h00, irq_o}, 8'h00);
    lvl1 <= 4'h8;
    tick(8);
    rd(DCC_OFF_IRQ_STAT, d);
    chk(d & 8'h03, 8'h01);
    chk({7'h00, irq_o}, 8'h01);
    wr(DCC_OFF_IRQ_MASK, 8'h02);
    tick(2);
    chk({7'h00, irq_o}, 8'h00);
    wr(DCC_OFF_IRQ_MASK, 8'h01);
    gie <= 1'b0;
    tick(5);
    chk({7'h00, irq_o}, 8'h00);
    gie <= 1'b1;
    tick(5);
    chk({7'h00, irq_o}, 8'h01);
    wr(DCC_OFF_COMPARATOR_ONE_CONTROL, 8'h20);
    tick(2);
    chk({7'h00, irq_o}, 8'h00);
    rd(DCC_OFF_COMPARATOR_ONE_CONTROL, d);
    chk(d, 8'h22);
    lvl1 <= 4'h0;
    tick(8);
    rd(DCC_OFF_COMPARATOR_ONE_CONTROL, d);
    chk(d, 8'h21);
    wr(DCC_OFF_COMPARATOR_ONE_CONTROL, 8'h21);
    rd(DCC_OFF_COMPARATOR_ONE_CONTROL, d);
    chk(d, 8'h21);
    wr(DCC_OFF_IRQ_STAT, 8'h01);
    tick(2);
    chk({7'h00, irq_o}, 8'h00);
    lvl1 <= 4'h8;
    tick(8);
    wr(DCC_OFF_COMPARATOR_ONE_CONTROL, 8'h00);
    tick(2);
    rd(DCC_OFF_COMPARATOR_ONE_CONTROL, d);
    chk(d, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
